//--- hdl/cop_pkg.sv
// Package for the constant off-time chopper: timing constants and state types.
// Assumes a 40 MHz reference clock; timer counts derive from times in nanoseconds, the pump count from its frequency in kHz.
package cop_pkg;

    // ==========================================================================
    // Clock and timing constants
    // ==========================================================================
    localparam int CLK_PERIOD_NS   = 25;
    localparam int GUARD_NS        = 1000;
    localparam int BLANK_NS        = 1000;
    localparam int MIN_ON_NS       = 2500;
    localparam int PUMP_FREQ_KHZ   = 600;
    localparam int OFF_DEF_NS      = 13000;
    // Least times round up, none below one cycle.
    localparam int GUARD_CYC  = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CYC  = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_DEF_CYC = (OFF_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Half period of the pump square wave, rounded down (33 cycles, 606 kHz).
    localparam int PUMP_HALF_CYC = (1000000 / CLK_PERIOD_NS) / (2 * PUMP_FREQ_KHZ);
    // Off time reaches 6 ms: 240000 cycles, so counters are 18 bits.
    localparam int CNT_W = 18;

    // ==========================================================================
    // Chopper states
    // ==========================================================================
    typedef enum logic [2:0] {
        COP_IDLE,
        COP_ON_GUARD,
        COP_ON,
        COP_OFF_GUARD,
        COP_OFF,
        COP_RET_GUARD
    } cop_state_t;

endpackage

//--- hdl/cop_chopper.sv
// Dual constant off-time PWM chopper with dead time, blanking and minimum on time.
// Assumes comparator outputs, decay select and enable arrive asynchronously from pins.
//
// Notes on behaviour
// R1 - Two independent choppers, one per bridge.
// R2 - Dead time between leg transistor switchings.
// R3 - Comparator trip starts off time immediately.
// R4 - Off interval is monostable plus dead time.
// R5 - Comparator ignored during blanking after turn-on.
// R6 - Minimum on time enforced every cycle.
// R7 - Off time programmable up to six milliseconds.
// R8 - Short on time keeps chopping, off fixed.
// R9 - Decay select low: fast decay, both off.
// R10 - Decay select high: slow decay, low-side off.
// R11 - Fast decay: only lower diode-side transistor rectifies.
// R12 - Fast decay: restore pair after dead time.
// R13 - Slow decay: opposite upper transistor rectifies.
// R14 - Slow decay: release upper, then lower on.
// R15 - Host drives enable through resistor and capacitor.
// R16 - Fault pull-down wired onto enable pin.
// R17 - Free-running pump oscillator near 600 kHz.
// R18 - Overcurrent pulls enable low until recovery.
// R19 - Enable low: all transistors off, idle.
// R20 - Timers are parameterised cycle counters.
`timescale 1ns/10ps

module cop_chopper
    import cop_pkg::*;
#(
    parameter logic [cop_pkg::CNT_W-1:0] OFF_CYC = cop_pkg::CNT_W'(cop_pkg::OFF_DEF_CYC)
) (
    // Clock, reset, enable
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic                      clk_en,
    // Control pins
    input  wire logic                      decay_slow_pin,
    input  wire logic                      enable_pin_in,
    input  wire logic                      fault_req,
    input  wire logic [1:0]                phase_dir,
    // Sense comparators, one per bridge
    input  wire logic [1:0]                sense_over_ref,
    // Gate drives per bridge: bit 0 is bridge A
    output logic [1:0]                     gate_hi1,
    output logic [1:0]                     gate_lo1,
    output logic [1:0]                     gate_hi2,
    output logic [1:0]                     gate_lo2,
    // Monostable activity, one per bridge
    output logic [1:0]                     off_interval_timing_pin,
    // Open-drain pull-down on enable
    output logic                           enable_pin_out,
    output logic                           enable_pin_oe,
    // Charge pump square wave
    output logic                           pump_oscillator_out
);
    import cop_pkg::*;

    // ==========================================================================
    // Input synchronisers
    // ==========================================================================
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] sync1_nxt;
    logic [4:0] sync2_nxt;
    logic       en_ok;
    logic       slow_sel;
    logic [1:0] trip;

    always_comb begin
        sync1_nxt = {decay_slow_pin, enable_pin_in, fault_req, sense_over_ref};
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else if (clk_en) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    assign trip     = sync2_r[1:0];
    // A pending fault overrides the host level on the shared pin.
    assign en_ok    = sync2_r[3] & ~sync2_r[2];  // R16
    assign slow_sel = sync2_r[4];

    // ==========================================================================
    // Enable pull-down
    // ==========================================================================
    // The pull-down only sinks; the external RC sets the recovery time.
    assign enable_pin_out = 1'b0;
    logic oe_r;
    logic oe_nxt;
    always_comb oe_nxt = sync2_r[2];  // R18
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            oe_r <= 1'b0;
        end else if (clk_en) begin
            oe_r <= oe_nxt;
        end
    end
    assign enable_pin_oe = oe_r;  // R16

    // ==========================================================================
    // Charge pump oscillator
    // ==========================================================================
    logic [5:0] pump_cnt_r;
    logic [5:0] pump_cnt_nxt;
    logic       pump_r;
    logic       pump_nxt;

    always_comb begin
        pump_cnt_nxt = pump_cnt_r + 6'h01;
        pump_nxt     = pump_r;
        if (pump_cnt_r == 6'(PUMP_HALF_CYC - 1)) begin
            pump_cnt_nxt = 6'h00;
            pump_nxt     = ~pump_r;  // R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pump_cnt_r <= 6'h00;
            pump_r     <= 1'b0;
        end else if (clk_en) begin
            pump_cnt_r <= pump_cnt_nxt;
            pump_r     <= pump_nxt;
        end
    end
    assign pump_oscillator_out = pump_r;

    // ==========================================================================
    // Chopper state per bridge
    // ==========================================================================
    // Phase dir 1 drives high side 1 and low side 2; dir 0 the opposite diagonal.
    // The direction is latched per bridge, so decay always acts on the pair that was conducting.
    cop_state_t             st_r      [2];
    cop_state_t             st_nxt    [2];
    logic [CNT_W-1:0]       cnt_r     [2];
    logic [CNT_W-1:0]       cnt_nxt   [2];
    logic [CNT_W-1:0]       on_cnt_r  [2];
    logic [CNT_W-1:0]       on_cnt_nxt[2];
    logic [1:0]             mono_r;
    logic [1:0]             mono_nxt;
    logic [1:0]             slow_r;
    logic [1:0]             slow_nxt;
    logic [1:0]             dir_r;
    logic [1:0]             dir_nxt;
    logic [1:0]             hi1_r;
    logic [1:0]             lo1_r;
    logic [1:0]             hi2_r;
    logic [1:0]             lo2_r;
    logic [1:0]             hi1_nxt;
    logic [1:0]             lo1_nxt;
    logic [1:0]             hi2_nxt;
    logic [1:0]             lo2_nxt;

    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == '0) ? '0 : v - CNT_W'(1);
    endfunction

    always_comb begin
        for (int b = 0; b < 2; b++) begin  // R1
            st_nxt[b]     = st_r[b];
            cnt_nxt[b]    = dec_sat(cnt_r[b]);
            on_cnt_nxt[b] = dec_sat(on_cnt_r[b]);
            mono_nxt[b]   = mono_r[b];
            slow_nxt[b]   = slow_r[b];
            dir_nxt[b]    = dir_r[b];
            hi1_nxt[b]    = 1'b0;
            lo1_nxt[b]    = 1'b0;
            hi2_nxt[b]    = 1'b0;
            lo2_nxt[b]    = 1'b0;
            case (st_r[b])
                COP_IDLE: begin
                    mono_nxt[b] = 1'b0;
                    dir_nxt[b]  = phase_dir[b];
                    if (en_ok) begin
                        st_nxt[b]  = COP_ON_GUARD;
                        cnt_nxt[b] = CNT_W'(GUARD_CYC);  // R2
                    end
                end
                COP_ON_GUARD, COP_RET_GUARD: begin
                    // Everything off except a held upper transistor in slow decay.
                    if (cnt_r[b] == '0) begin
                        st_nxt[b]     = COP_ON;
                        on_cnt_nxt[b] = CNT_W'(MIN_ON_CYC);  // R6
                        cnt_nxt[b]    = CNT_W'(BLANK_CYC);  // R5
                    end
                end
                COP_ON: begin
                    hi1_nxt[b] = dir_r[b];
                    lo2_nxt[b] = dir_r[b];
                    hi2_nxt[b] = ~dir_r[b];
                    lo1_nxt[b] = ~dir_r[b];
                    // Trip honoured only after blanking and the minimum on time.
                    if (phase_dir[b] != dir_r[b]) begin  // R2
                        // Swapping diagonals in one step would cross both legs, so all go off for a guard.
                        st_nxt[b]  = COP_ON_GUARD;
                        dir_nxt[b] = phase_dir[b];
                        cnt_nxt[b] = CNT_W'(GUARD_CYC);
                        hi1_nxt[b] = 1'b0;
                        lo1_nxt[b] = 1'b0;
                        hi2_nxt[b] = 1'b0;
                        lo2_nxt[b] = 1'b0;
                    end else if (trip[b] && cnt_r[b] == '0 && on_cnt_r[b] == '0) begin  // R3 R5 R6
                        st_nxt[b]   = COP_OFF_GUARD;
                        slow_nxt[b] = slow_sel;
                        mono_nxt[b] = 1'b1;
                        cnt_nxt[b]  = CNT_W'(GUARD_CYC);
                        hi1_nxt[b]  = dir_r[b] & slow_sel;  // R9 R10
                        hi2_nxt[b]  = ~dir_r[b] & slow_sel;  // R10
                        lo1_nxt[b]  = 1'b0;
                        lo2_nxt[b]  = 1'b0;
                    end
                end
                COP_OFF_GUARD: begin
                    hi1_nxt[b] = dir_r[b] & slow_r[b];
                    hi2_nxt[b] = ~dir_r[b] & slow_r[b];
                    if (cnt_r[b] == '0) begin
                        st_nxt[b]  = COP_OFF;
                        // Monostable counts from the trip; guard already spent.
                        cnt_nxt[b] = (OFF_CYC > CNT_W'(GUARD_CYC)) ? OFF_CYC - CNT_W'(GUARD_CYC) : '0;  // R7 R20
                    end
                end
                COP_OFF: begin
                    if (slow_r[b]) begin
                        hi1_nxt[b] = 1'b1;  // R13
                        hi2_nxt[b] = 1'b1;  // R13
                    end else begin
                        // Only the lower transistor beside the conducting diode.
                        lo1_nxt[b] = dir_r[b];  // R11
                        lo2_nxt[b] = ~dir_r[b];  // R11
                    end
                    if (cnt_r[b] == '0) begin
                        st_nxt[b]   = COP_RET_GUARD;
                        mono_nxt[b] = 1'b0;
                        cnt_nxt[b]  = CNT_W'(GUARD_CYC);  // R4 R12 R14
                        // Slow decay keeps only the original upper one; fast drops all.
                        hi1_nxt[b]  = dir_r[b] & slow_r[b];  // R14
                        hi2_nxt[b]  = ~dir_r[b] & slow_r[b];  // R14
                        lo1_nxt[b]  = 1'b0;
                        lo2_nxt[b]  = 1'b0;
                    end
                end
                default: begin
                    st_nxt[b] = COP_IDLE;
                end
            endcase
            if (st_r[b] == COP_RET_GUARD) begin
                hi1_nxt[b] = dir_r[b] & slow_r[b];
                hi2_nxt[b] = ~dir_r[b] & slow_r[b];
            end
            // The monostable runs its full time regardless of the on time (R8).
            if (!en_ok) begin  // R19
                st_nxt[b]   = COP_IDLE;
                mono_nxt[b] = 1'b0;
                hi1_nxt[b]  = 1'b0;
                lo1_nxt[b]  = 1'b0;
                hi2_nxt[b]  = 1'b0;
                lo2_nxt[b]  = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int b = 0; b < 2; b++) begin
                st_r[b]     <= COP_IDLE;
                cnt_r[b]    <= '0;
                on_cnt_r[b] <= '0;
            end
            mono_r <= 2'h0;
            dir_r  <= 2'h0;
            slow_r <= 2'h0;
            hi1_r  <= 2'h0;
            lo1_r  <= 2'h0;
            hi2_r  <= 2'h0;
            lo2_r  <= 2'h0;
        end else if (clk_en) begin
            for (int b = 0; b < 2; b++) begin
                st_r[b]     <= st_nxt[b];
                cnt_r[b]    <= cnt_nxt[b];
                on_cnt_r[b] <= on_cnt_nxt[b];
            end
            mono_r <= mono_nxt;
            dir_r  <= dir_nxt;
            slow_r <= slow_nxt;
            hi1_r  <= hi1_nxt;
            lo1_r  <= lo1_nxt;
            hi2_r  <= hi2_nxt;
            lo2_r  <= lo2_nxt;
        end
    end

    assign gate_hi1                = hi1_r;
    assign gate_lo1                = lo1_r;
    assign gate_hi2                = hi2_r;
    assign gate_lo2                = lo2_r;
    assign off_interval_timing_pin = mono_r;

endmodule

//--- testbench/cop_chopper_assertions.sv
// Checker for the chopper: leg guard, trip response, off span, on time, enable and pump.
// Assumes clk_en is high while the bridges switch and decay select changes only while they are disabled.
`timescale 1ns/10ps
module cop_chopper_assertions
    import cop_pkg::*;
#(
    parameter logic [cop_pkg::CNT_W-1:0] OFF_CYC = cop_pkg::CNT_W'(cop_pkg::OFF_DEF_CYC)
) (
    // Clock, reset and pins
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       decay_slow_pin,
    input wire logic       enable_pin_in,
    input wire logic       fault_req,
    // Chopper outputs
    input wire logic [1:0] gate_hi1,
    input wire logic [1:0] gate_lo1,
    input wire logic [1:0] gate_hi2,
    input wire logic [1:0] gate_lo2,
    input wire logic [1:0] off_interval_timing_pin,
    input wire logic       enable_pin_out,
    input wire logic       enable_pin_oe,
    input wire logic       pump_oscillator_out
);
    // ====================================================================
    // Helper counters
    logic [3:0]  g, g_r;
    logic        on_b, pump_r, seen_r, seen_nxt;
    logic [17:0] dt_r, dt_nxt, on_r, on_nxt, tm_r, tm_nxt, pc_r, pc_nxt;
    assign g    = {gate_hi1[0], gate_lo1[0], gate_hi2[0], gate_lo2[0]};
    assign on_b = (gate_hi1[1] && gate_lo2[1]) || (gate_hi2[1] && gate_lo1[1]);
    // Counters saturate so that long idle spells cannot wrap into false gaps.
    function automatic logic [17:0] up(input logic [17:0] v);
        return (v < 18'h3e8) ? v + 18'h1 : v;
    endfunction
    always_comb begin
        dt_nxt   = |(g_r & ~g) ? 18'h0 : up(dt_r);
        on_nxt   = on_b ? up(on_r) : 18'h0;
        tm_nxt   = off_interval_timing_pin[0] ? up(tm_r) : 18'h0;
        pc_nxt   = (pump_oscillator_out != pump_r) ? 18'h0 : up(pc_r);
        seen_nxt = seen_r || (pump_oscillator_out != pump_r);
    end
    always_ff @(posedge ref_clk) begin
        g_r    <= srst ? 4'h0 : g;
        pump_r <= srst ? 1'b0 : pump_oscillator_out;
        seen_r <= srst ? 1'b0 : seen_nxt;
        dt_r   <= srst ? 18'h0 : dt_nxt;
        on_r   <= srst ? 18'h0 : on_nxt;
        tm_r   <= srst ? 18'h0 : tm_nxt;
        pc_r   <= srst ? 18'h0 : pc_nxt;
    end
    // ====================================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_trip;
        $rose(off_interval_timing_pin[0]);
    endsequence
    sequence s_trip_b;
        $rose(off_interval_timing_pin[1]);
    endsequence
    a_leg_exclusive: assert property (!(|(gate_hi1 & gate_lo1)) && !(|(gate_hi2 & gate_lo2)))
        else $error("both gates of one leg are on");
    a_guard_gap: assert property (|(g & ~g_r) |-> dt_r >= GUARD_CYC - 1)
        else $error("gate turned on too soon after a turn-off");
    a_trip_lows: assert property (s_trip |-> !gate_lo1[0] && !gate_lo2[0])
        else $error("low side still on at trip");
    a_fast_free: assert property (off_interval_timing_pin[0] && !decay_slow_pin |-> !gate_hi1[0] && !gate_hi2[0])
        else $error("upper gate on during fast decay");
    a_slow_keep: assert property ((s_trip and decay_slow_pin) |-> (gate_hi1[0] || gate_hi2[0]))
        else $error("conducting upper gate dropped in slow decay");
    a_slow_sync: assert property ((s_trip and decay_slow_pin) |-> ##[38:45] (gate_hi1[0] && gate_hi2[0]))
        else $error("no synchronous upper recirculation");
    a_off_span: assert property ($fell(off_interval_timing_pin[0]) && enable_pin_in |-> tm_r >= OFF_CYC && tm_r <= OFF_CYC + 18'h3)
        else $error("off interval has the wrong length");
    a_min_on: assert property (s_trip_b |-> on_r >= MIN_ON_CYC)
        else $error("trip before the minimum on time");
    a_idle_off: assert property ($fell(enable_pin_in) |-> ##[1:4] !(|{gate_hi1, gate_lo1, gate_hi2, gate_lo2}))
        else $error("gates on while disabled");
    a_fault_pull: assert property ($rose(fault_req) |-> ##[1:4] (enable_pin_oe && !enable_pin_out))
        else $error("enable not pulled low on fault");
    a_pump_half: assert property ($changed(pump_oscillator_out) && seen_r |-> pc_r == PUMP_HALF_CYC - 1)
        else $error("pump half period is wrong");
endmodule

bind cop_chopper cop_chopper_assertions #(.OFF_CYC(OFF_CYC)) i_chk (.*);

//--- testbench/cop_motor_model.sv
// Two windings with sense resistors: current rises while a diagonal pair conducts.
// Assumes gates are registered on ref_clk; the comparator trips at a limit per bridge.
`timescale 1ns/10ps
module cop_motor_model #(
    parameter int LIM_A = 200,
    parameter int LIM_B = 5
) (
    // Clock and gates
    input  wire logic       ref_clk,
    input  wire logic [1:0] gate_hi1,
    input  wire logic [1:0] gate_lo1,
    input  wire logic [1:0] gate_hi2,
    input  wire logic [1:0] gate_lo2,
    // Comparator outputs
    output logic [1:0]      sense_over_ref
);
    // ====================================================================
    // Winding current
    // Bridge B trips almost at once, so its on time is set by the chopper alone.
    int cur [2];
    always @(posedge ref_clk) begin
        for (int b = 0; b < 2; b++) begin
            if ((gate_hi1[b] && gate_lo2[b]) || (gate_hi2[b] && gate_lo1[b]))
                cur[b] <= cur[b] + 1;
            else if (cur[b] > 0)
                cur[b] <= cur[b] - 1;
        end
    end
    assign sense_over_ref = {cur[1] > LIM_B, cur[0] > LIM_A};
endmodule

//--- testbench/tb.sv
// Self-checking bench for the dual chopper with a winding model on both bridges.
// Assumes a 40 MHz clock; the off time is shortened to 100 cycles.
`timescale 1ns/10ps
module tb;
    import cop_pkg::*;
    // ====================================================================
    // Signals and instances
    localparam logic [CNT_W-1:0] OFF_T = 18'h64;
    logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, decay_slow_pin = 1'b0;
    logic host_en = 1'b0, fault_req = 1'b0, enable_pin_out, enable_pin_oe, pump_oscillator_out;
    logic [1:0] phase_dir = 2'h1, sense_over_ref, gate_hi1, gate_lo1, gate_hi2, gate_lo2;
    logic [1:0] off_interval_timing_pin;
    wire        enable_pin_in;
    int err_count = 0, n_checks = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    // Host drives through a pull-up; the device pull-down overrides it.
    assign enable_pin_in = enable_pin_oe ? enable_pin_out : host_en;
    cop_chopper #(.OFF_CYC(OFF_T)) i_dut (.*);
    cop_motor_model i_motor (.*);
    // ====================================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] br(input int b);
        return {4'h0, gate_hi1[b], gate_lo1[b], gate_hi2[b], gate_lo2[b]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_off(input int b, input logic lv);
        for (int i = 0; i < 3000 && off_interval_timing_pin[b] !== lv; i++) tick(1);
        chk({7'h0, off_interval_timing_pin[b]}, {7'h0, lv});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ====================================================================
    // Scenarios
    task automatic test_fast();
        wait_off(0, 1'b1);
        chk(br(0), 8'h0);
        tick(30); chk(br(0), 8'h0);
        tick(20); chk(br(0), 8'h4);
        wait_off(0, 1'b0);
        tick(30); chk(br(0), 8'h0);
        tick(20); chk(br(0), 8'h9);
        wait_off(1, 1'b1);
        wait_off(1, 1'b0);
        tick(50); chk(br(1), 8'h6);
        $display("fast decay test done");
    endtask
    task automatic test_disable();
        @(posedge ref_clk) host_en <= 1'b0;
        tick(6); chk(br(0) | br(1), 8'h0);
        @(posedge ref_clk) decay_slow_pin <= 1'b1;
        host_en <= 1'b1;
        $display("disable test done");
    endtask
    task automatic test_slow();
        wait_off(0, 1'b1);
        chk(br(0), 8'h8);
        tick(50); chk(br(0), 8'ha);
        wait_off(0, 1'b0);
        chk(br(0), 8'h8);
        tick(50); chk(br(0), 8'h9);
        $display("slow decay test done");
    endtask
    task automatic test_fault();
        @(posedge ref_clk) fault_req <= 1'b1;
        tick(5); chk({6'h0, enable_pin_oe, enable_pin_out}, 8'h2);
        chk(br(0) | br(1), 8'h0);
        @(posedge ref_clk) fault_req <= 1'b0;
        tick(6); chk({7'h0, enable_pin_oe}, 8'h0);
        tick(50); chk(br(0), 8'h9);
        $display("fault test done");
    endtask
    task automatic test_dir();
        @(posedge ref_clk) phase_dir <= 2'h0;
        tick(3); chk(br(0), 8'h0);
        tick(50); chk(br(0), 8'h6);
        $display("direction test done");
    endtask
    task automatic test_freeze();
        logic [7:0] s0;
        logic [7:0] s1;
        @(posedge ref_clk) clk_en <= 1'b0;
        #1;
        s0 = br(0) | {3'h0, pump_oscillator_out, 4'h0};
        s1 = br(1) | {2'h0, off_interval_timing_pin, 4'h0};
        tick(40);
        chk(br(0) | {3'h0, pump_oscillator_out, 4'h0}, s0);
        chk(br(1) | {2'h0, off_interval_timing_pin, 4'h0}, s1);
        $display("freeze test done");
    endtask
    task automatic test_pump();
        logic p;
        int   n;
        p = pump_oscillator_out;
        for (n = 0; n < 100 && pump_oscillator_out === p; n++) tick(1);
        p = pump_oscillator_out;
        for (n = 0; n < 100 && pump_oscillator_out === p; n++) tick(1);
        chk(8'(n), 8'(PUMP_HALF_CYC));
        $display("pump test done");
    endtask
    // ====================================================================
    // Main sequence and timeout
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("timeout after %0d cycles", cyc);
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        tick(3); chk(br(0) | br(1), 8'h0);
        @(posedge ref_clk) host_en <= 1'b1;
        test_fast();
        test_disable();
        test_slow();
        test_fault();
        test_dir();
        test_pump();
        test_freeze();
        complete_run();
    end
endmodule
